// ### champm_defs.vh
// Constants for the channel A pin mode mux: register map, mode codes, fields.
// Assumes inclusion by bare name from the design files.
`ifndef CHAMPM_DEFS_VH
`define CHAMPM_DEFS_VH
// APB register byte offsets
`define CHAMPM_OFS_BASE      12'h000
`define CHAMPM_OFS_BITMODE   12'h004
`define CHAMPM_OFS_CHB       12'h008
`define CHAMPM_OFS_STATUS    12'h00c
`define CHAMPM_OFS_FUNC_OUT  12'h010
`define CHAMPM_OFS_FUNC_OE   12'h014
`define CHAMPM_OFS_PINS_IN   12'h018
// Base modes from the configuration memory
`define CHAMPM_BASE_SERIAL   3'h0
`define CHAMPM_BASE_FIFO     3'h1
`define CHAMPM_BASE_CPUFIFO  3'h2
`define CHAMPM_BASE_OPTO     3'h3
`define CHAMPM_BASE_BLANK    3'h7
// Bit mode command values
`define CHAMPM_BM_RESET      8'h00
`define CHAMPM_BM_ASYNC_BB   8'h01
`define CHAMPM_BM_ENGINE     8'h02
`define CHAMPM_BM_SYNC_BB    8'h04
`define CHAMPM_BM_HOSTBUS    8'h08
`define CHAMPM_BM_OPTO       8'h10
// Channel B mode codes
`define CHAMPM_CHB_OTHER     2'h0
`define CHAMPM_CHB_OPTO      2'h1
`define CHAMPM_CHB_HOSTBUS   2'h2
// Reset values
`define CHAMPM_RST_BASE      3'h7
`define CHAMPM_RST_BITMODE   8'h00
// Status fields
`define CHAMPM_ST_MODE_LSB   0
`define CHAMPM_ST_OPTO_RST   8
`define CHAMPM_ST_SI_EN      9
`define CHAMPM_ST_REFUSED    10
`endif

// ### champm_sync.v
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes the inputs are asynchronous to pclk.
`default_nettype none
module champm_sync #(
   parameter W = 13
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);
   reg [W-1:0] stage1;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1   <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // champm_sync
`default_nettype wire

// ### champm_mux.v
// Channel A pin function multiplexer with APB register access.
// Assumes APB master on pclk; pins are external and synchronised here.
// Function
// RULE1 - Missing or blank configuration memory forces serial mode.
// RULE2 - Serial, FIFO, CPU FIFO, opto base modes come only from configuration.
// RULE3 - Bit-bang, engine and host-bus modes enter only by bit mode command.
// RULE4 - Decode command: 0 base, 1 async BB, 2 engine, 4 sync BB, 8 host, 10 opto.
// RULE5 - Opto mode: value 10 holds it in reset, 0 releases it.
// RULE6 - Serial engine mode only on channel A; refused on channel B.
// RULE7 - Host-bus mode takes both channels; channel B unavailable meanwhile.
// RULE8 - Channel B in opto leaves channel A free for other modes.
// RULE9 - Both channels opto: all opto signals on channel B, A unused; code still lets the channel A suspend/wake pin drive.
// RULE10 - Bit-bang over FIFO/CPU/opto base: write strobe high pin 0, read pin 1.
// RULE11 - Bit-bang over serial base: write strobe high pin 2, read pin 3; code uses high pins 0 and 1 while base still holds the blank reset value 7.
// RULE12 - Suspend/wake absent in engine and host-bus modes, present otherwise.
// RULE13 - Serial mode low pins carry TXD RXD RTS CTS DTR DSR DCD RI.
// RULE14 - Serial/FIFO high nibble functions as specified in order.
// RULE15 - Engine mode: low 0-3 serial engine, 4-7 and high nibble general bits.
// RULE16 - Host-bus: low byte address/data, high 0-1 I/O, 2 ready, 3 clock.
// RULE17 - FIFO and bit-bang modes: low byte is data bus 0-7.
// RULE18 - Unassigned pins stay inputs; mode switch is atomic.
`default_nettype none
`include "champm_defs.vh"
module champm_mux (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        config_present,
   input  wire        config_blank,
   input  wire [2:0]  config_base_mode,
   input  wire        config_valid,
   input  wire [1:0]  channel_b_mode,
   input  wire        channel_b_bitmode_engine_req,
   input  wire [7:0]  core_low_out,
   input  wire [7:0]  core_low_oe,
   input  wire [3:0]  core_high_out,
   input  wire [3:0]  core_high_oe,
   input  wire        core_suspend_out,
   input  wire        core_suspend_oe,
   input  wire [7:0]  port_a_low_byte_in,
   output reg  [7:0]  port_a_low_byte_out,
   output reg  [7:0]  port_a_low_byte_oe,
   input  wire [3:0]  port_a_high_nibble_in,
   output reg  [3:0]  port_a_high_nibble_out,
   output reg  [3:0]  port_a_high_nibble_oe,
   input  wire        suspend_indicate_wakeup_a_in,
   output reg         suspend_indicate_wakeup_a_out,
   output reg         suspend_indicate_wakeup_a_oe,
   output reg  [7:0]  core_low_in,
   output reg  [3:0]  core_high_in,
   output reg         core_suspend_in,
   output reg  [3:0]  active_mode,
   output reg         opto_held_reset,
   output reg         channel_b_engine_refused,
   output reg         channel_b_blocked
);
   // Effective mode codes, one-hot states
   localparam M_SERIAL = 9'h001;
   localparam M_FIFO   = 9'h002;
   localparam M_CPU    = 9'h004;
   localparam M_OPTO   = 9'h008;
   localparam M_ABB    = 9'h010;
   localparam M_SBB    = 9'h020;
   localparam M_ENGINE = 9'h040;
   localparam M_HOST   = 9'h080;
   localparam M_IDLE   = 9'h100;

   reg  [2:0] base_mode;
   reg  [7:0] bit_mode;
   reg  [8:0] mode;
   reg  [8:0] next_mode;
   reg        refused;
   wire [12:0] pins_sync;
   wire [7:0]  low_in  = pins_sync[7:0];
   wire [3:0]  high_in = pins_sync[11:8];
   wire        si_in   = pins_sync[12];

   champm_sync #(.W(13)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({suspend_indicate_wakeup_a_in, port_a_high_nibble_in, port_a_low_byte_in}),
      .sync_out (pins_sync)
   );

   // Base mode is a config-memory decode only; software cannot write it
   function [2:0] base_decode;
      input       present;
      input       blank;
      input [2:0] code;
      begin
         if (!present || blank)
            base_decode = `CHAMPM_BASE_SERIAL; // [RULE1]
         else if (code > `CHAMPM_BASE_OPTO)
            base_decode = `CHAMPM_BASE_SERIAL;
         else
            base_decode = code; // [RULE2]
      end
   endfunction

   function is_bitbang;
      input [8:0] m;
      begin
         is_bitbang = (m == M_ABB) || (m == M_SBB);
      end
   endfunction

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         base_mode <= `CHAMPM_RST_BASE;
      else if (config_valid)
         base_mode <= base_decode(config_present, config_blank, config_base_mode);
   end

   // APB: zero wait state, unmapped reads zero and flag error
   wire apb_acc = psel && penable;
   wire wr_en   = apb_acc && pwrite;
   wire mapped  = (paddr == `CHAMPM_OFS_BASE) || (paddr == `CHAMPM_OFS_BITMODE) ||
                  (paddr == `CHAMPM_OFS_CHB) || (paddr == `CHAMPM_OFS_STATUS) ||
                  (paddr == `CHAMPM_OFS_FUNC_OUT) || (paddr == `CHAMPM_OFS_FUNC_OE) ||
                  (paddr == `CHAMPM_OFS_PINS_IN);
   assign pready  = 1'b1;
   assign pslverr = apb_acc && !mapped;

   // Bit mode register: the host driver command lands here
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_mode <= `CHAMPM_RST_BITMODE;
         refused  <= 1'b0;
      end else if (wr_en && paddr == `CHAMPM_OFS_BITMODE) begin
         bit_mode <= pwdata[7:0]; // [RULE3]
         refused  <= !(pwdata[7:0] == `CHAMPM_BM_RESET ||
                       pwdata[7:0] == `CHAMPM_BM_ASYNC_BB ||
                       pwdata[7:0] == `CHAMPM_BM_ENGINE ||
                       pwdata[7:0] == `CHAMPM_BM_SYNC_BB ||
                       pwdata[7:0] == `CHAMPM_BM_HOSTBUS ||
                       pwdata[7:0] == `CHAMPM_BM_OPTO);
      end
   end

   // Opto reset: 10 holds, 0 releases
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         opto_held_reset <= 1'b0;
      else if (wr_en && paddr == `CHAMPM_OFS_BITMODE && base_mode == `CHAMPM_BASE_OPTO) begin
         if (pwdata[7:0] == `CHAMPM_BM_OPTO)
            opto_held_reset <= 1'b1; // [RULE5]
         else if (pwdata[7:0] == `CHAMPM_BM_RESET)
            opto_held_reset <= 1'b0; // [RULE5]
      end
   end

   // Effective mode selection
   always @* begin
      case (bit_mode)
         `CHAMPM_BM_ASYNC_BB: next_mode = M_ABB; // [RULE4]
         `CHAMPM_BM_SYNC_BB:  next_mode = M_SBB; // [RULE4]
         `CHAMPM_BM_ENGINE:   next_mode = M_ENGINE; // [RULE4] [RULE6]
         `CHAMPM_BM_HOSTBUS:  next_mode = M_HOST; // [RULE4]
         default: begin
            case (base_mode)
               `CHAMPM_BASE_SERIAL:  next_mode = M_SERIAL;
               `CHAMPM_BASE_FIFO:    next_mode = M_FIFO;
               `CHAMPM_BASE_CPUFIFO: next_mode = M_CPU;
               `CHAMPM_BASE_OPTO:    next_mode = M_OPTO;
               default:              next_mode = M_SERIAL; // [RULE1]
            endcase
         end
      endcase
      // Both channels opto: channel A low byte and high nibble idle, suspend/wake still allowed
      if (next_mode == M_OPTO && channel_b_mode == `CHAMPM_CHB_OPTO)
         next_mode = M_IDLE; // [RULE9]
      // Channel B opto alone does not restrict channel A [RULE8]
   end

   // Registered mode so every pin switches on one edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode                     <= M_IDLE;
         channel_b_engine_refused <= 1'b0;
         channel_b_blocked        <= 1'b0;
         active_mode              <= 4'h8; // Matches the idle reset mode
      end else begin
         mode                     <= next_mode; // [RULE18]
         channel_b_engine_refused <= channel_b_bitmode_engine_req; // [RULE6]
         channel_b_blocked        <= (next_mode == M_HOST); // [RULE7]
         case (next_mode)
            M_SERIAL: active_mode <= 4'h0;
            M_FIFO:   active_mode <= 4'h1;
            M_CPU:    active_mode <= 4'h2;
            M_OPTO:   active_mode <= 4'h3;
            M_ABB:    active_mode <= 4'h4;
            M_SBB:    active_mode <= 4'h5;
            M_ENGINE: active_mode <= 4'h6;
            M_HOST:   active_mode <= 4'h7;
            default:  active_mode <= 4'h8;
         endcase
      end
   end

   // Pin routing: the core supplies per-pin function data and enables,
   // this block decides which pins may drive at all
   reg [7:0] lo_mask;
   reg [3:0] hi_mask;
   reg       si_allow;
   always @* begin
      lo_mask  = 8'h00;
      hi_mask  = 4'h0;
      si_allow = 1'b1;
      case (mode)
         M_SERIAL: begin
            lo_mask = 8'hff; // [RULE13] TXD RXD RTS CTS DTR DSR DCD RI
            hi_mask = 4'hf; // [RULE14] driver enable, sleep, rx led, tx led
         end
         M_FIFO, M_CPU: begin
            lo_mask = 8'hff; // [RULE17]
            hi_mask = 4'hf; // [RULE14] rx avail, tx empty, rd, wr
         end
         M_ABB, M_SBB: begin
            lo_mask = 8'hff; // [RULE17]
            if (base_mode == `CHAMPM_BASE_SERIAL)
               hi_mask = 4'hc; // [RULE11]
            else
               hi_mask = 4'h3; // [RULE10]
         end
         M_ENGINE: begin
            lo_mask  = 8'hff; // [RULE15]
            hi_mask  = 4'hf; // [RULE15]
            si_allow = 1'b0; // [RULE12]
         end
         M_HOST: begin
            lo_mask  = 8'hff; // [RULE16]
            hi_mask  = 4'hb; // [RULE16] pin 2 is ready input
            si_allow = 1'b0; // [RULE12]
         end
         M_OPTO: begin
            lo_mask = 8'h00;
            hi_mask = 4'h0;
         end
         M_IDLE: begin
            lo_mask = 8'h00; // [RULE9]
            hi_mask = 4'h0;
         end
         default: begin
            lo_mask  = 8'h00; // [RULE18]
            hi_mask  = 4'h0;
            si_allow = 1'b0;
         end
      endcase
   end

   // Registered pin drive; unassigned pins are undriven inputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_a_low_byte_out           <= 8'h00;
         port_a_low_byte_oe            <= 8'h00;
         port_a_high_nibble_out        <= 4'h0;
         port_a_high_nibble_oe         <= 4'h0;
         suspend_indicate_wakeup_a_out <= 1'b0;
         suspend_indicate_wakeup_a_oe  <= 1'b0;
         core_low_in                   <= 8'h00;
         core_high_in                  <= 4'h0;
         core_suspend_in               <= 1'b0;
      end else begin
         port_a_low_byte_out           <= core_low_out & lo_mask;
         port_a_low_byte_oe            <= core_low_oe & lo_mask; // [RULE18]
         port_a_high_nibble_out        <= core_high_out & hi_mask;
         port_a_high_nibble_oe         <= core_high_oe & hi_mask; // [RULE18]
         suspend_indicate_wakeup_a_out <= core_suspend_out & si_allow;
         suspend_indicate_wakeup_a_oe  <= core_suspend_oe & si_allow; // [RULE12]
         core_low_in                   <= low_in & lo_mask;
         core_high_in                  <= high_in & (hi_mask | ((mode == M_HOST) ? 4'h4 : 4'h0));
         core_suspend_in               <= si_in & si_allow;
      end
   end

   // Read mux
   always @* begin
      prdata = 32'h0000_0000;
      if (apb_acc && !pwrite) begin
         case (paddr)
            `CHAMPM_OFS_BASE:     prdata = {29'h0, base_mode};
            `CHAMPM_OFS_BITMODE:  prdata = {24'h0, bit_mode};
            `CHAMPM_OFS_CHB:      prdata = {28'h0, channel_b_engine_refused,
                                            channel_b_blocked, channel_b_mode};
            `CHAMPM_OFS_STATUS:   prdata = {21'h0, refused, si_allow, opto_held_reset,
                                            4'h0, active_mode};
            `CHAMPM_OFS_FUNC_OUT: prdata = {19'h0, suspend_indicate_wakeup_a_out,
                                            port_a_high_nibble_out, port_a_low_byte_out};
            `CHAMPM_OFS_FUNC_OE:  prdata = {19'h0, suspend_indicate_wakeup_a_oe,
                                            port_a_high_nibble_oe, port_a_low_byte_oe};
            `CHAMPM_OFS_PINS_IN:  prdata = {19'h0, si_in, high_in, low_in};
            default:              prdata = 32'h0000_0000;
         endcase
      end
   end
endmodule // champm_mux
`default_nettype wire

// ### champm_chk.sv
// Port assertions for the channel A pin mode mux.
// Assumes one pclk domain with presetn active low; bound to champm_mux.
`default_nettype none
module champm_chk (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic [3:0] active_mode,
   input wire logic [7:0] core_low_oe,
   input wire logic [7:0] port_a_low_byte_oe,
   input wire logic [3:0] port_a_high_nibble_oe,
   input wire logic       suspend_indicate_wakeup_a_oe,
   input wire logic       channel_b_bitmode_engine_req,
   input wire logic       channel_b_engine_refused,
   input wire logic       channel_b_blocked
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_engine_no_wake: assert property (active_mode == 4'h6 |=> !suspend_indicate_wakeup_a_oe)
      else $error("wake pin driven in engine mode");
   a_host_no_wake: assert property (active_mode == 4'h7 |=> !suspend_indicate_wakeup_a_oe)
      else $error("wake pin driven in host-bus mode");
   a_idle_pins_off: assert property (active_mode == 4'h8 |=>
      port_a_low_byte_oe == 8'h00 && port_a_high_nibble_oe == 4'h0)
      else $error("pins driven while both channels opto");
   a_host_blocks_b: assert property (active_mode == 4'h7 [*3] |-> channel_b_blocked)
      else $error("channel B not blocked in host-bus mode");
   a_engine_b_refused: assert property (channel_b_bitmode_engine_req |=> channel_b_engine_refused)
      else $error("engine request on channel B not refused");
   a_serial_low_pass: assert property (active_mode == 4'h0 |=>
      port_a_low_byte_oe == $past(core_low_oe))
      else $error("serial low byte enables wrong");
   a_bitbang_data_bus: assert property (active_mode inside {4'h4, 4'h5} |=>
      port_a_low_byte_oe == $past(core_low_oe))
      else $error("bit-bang data bus enables wrong");
   a_host_ready_in: assert property (active_mode == 4'h7 |=> !port_a_high_nibble_oe[2])
      else $error("ready pin driven in host-bus mode");
endmodule // champm_chk
bind champm_mux champm_chk u_champm_chk (.*);
`default_nettype wire

// ### champm_pins.sv
// External logic on the channel A pins: resolves each pin from both drivers.
// Assumes the bench supplies what the far side drives where the device lets go.
`default_nettype none
module champm_pins (
   input  wire logic [7:0]  port_a_low_byte_out,
   input  wire logic [7:0]  port_a_low_byte_oe,
   input  wire logic [3:0]  port_a_high_nibble_out,
   input  wire logic [3:0]  port_a_high_nibble_oe,
   input  wire logic        suspend_indicate_wakeup_a_out,
   input  wire logic        suspend_indicate_wakeup_a_oe,
   input  wire logic [12:0] ext_drive,
   output logic [7:0]       port_a_low_byte_in,
   output logic [3:0]       port_a_high_nibble_in,
   output logic             suspend_indicate_wakeup_a_in
);
   // Far side drives only released pins, so no two drivers meet
   assign port_a_low_byte_in = (port_a_low_byte_out & port_a_low_byte_oe)
                             | (ext_drive[7:0] & ~port_a_low_byte_oe);
   assign port_a_high_nibble_in = (port_a_high_nibble_out & port_a_high_nibble_oe)
                                | (ext_drive[11:8] & ~port_a_high_nibble_oe);
   assign suspend_indicate_wakeup_a_in = suspend_indicate_wakeup_a_oe ?
                                         suspend_indicate_wakeup_a_out : ext_drive[12];
endmodule // champm_pins
`default_nettype wire

// ### tb_champm_mux.sv
// Self-checking bench for the channel A pin mode mux.
// Assumes zero-wait APB, mode one edge and pins two edges after a write.
`default_nettype none
`include "champm_defs.vh"
module tb_champm_mux;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        config_present, config_blank, config_valid, channel_b_bitmode_engine_req;
   logic        core_suspend_out, core_suspend_oe, core_suspend_in, opto_held_reset;
   logic        suspend_indicate_wakeup_a_in, suspend_indicate_wakeup_a_out;
   logic        suspend_indicate_wakeup_a_oe, channel_b_engine_refused, channel_b_blocked;
   logic [2:0]  config_base_mode;
   logic [1:0]  channel_b_mode;
   logic [7:0]  core_low_out, core_low_oe, core_low_in;
   logic [7:0]  port_a_low_byte_in, port_a_low_byte_out, port_a_low_byte_oe;
   logic [3:0]  core_high_out, core_high_oe, core_high_in, active_mode;
   logic [3:0]  port_a_high_nibble_in, port_a_high_nibble_out, port_a_high_nibble_oe;
   logic [12:0] ext_drive;
   int          error_cnt, comparisons, b;
   int          bms[6] = '{1, 2, 4, 8, 3, 0};
   champm_mux  u_champm_mux (.*);
   champm_pins u_champm_pins (.*);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         error_cnt++;
         conclude();
      end
   endtask
   // Reference mode from base, command and channel B state
   function automatic int exp_mode(int base, int bm);
      case (bm)
         1: return 4;
         2: return 6;
         4: return 5;
         8: return 7;
         default: return (base == 3 && channel_b_mode == 1) ? 8 : (base == 7 ? 0 : base);
      endcase
   endfunction
   function automatic logic [12:0] pmask(int md, int base);
      case (md)
         4, 5: return {1'b1, (base == 0) ? 4'hc : 4'h3, 8'hff};
         6: return {1'b0, 4'hf, 8'hff};
         7: return {1'b0, 4'hb, 8'hff};
         3, 8: return 13'h1000;
         default: return 13'h1fff;
      endcase
   endfunction
   task automatic go(input int base, input int bm);
      int   em;
      logic bad;
      @(posedge pclk);
      em  = exp_mode(base, bm);
      bad = !(bm inside {0, 1, 2, 4, 8, 16});
      {core_low_out, core_low_oe} <= 16'($urandom);
      apb(1'b1, `CHAMPM_OFS_BITMODE, bm);
      repeat (2) @(posedge pclk);
      #1;
      chk(active_mode, em);
      chk({suspend_indicate_wakeup_a_oe, port_a_high_nibble_oe, port_a_low_byte_oe},
          {core_suspend_oe, core_high_oe, core_low_oe} & pmask(em, base));
      chk({suspend_indicate_wakeup_a_out, port_a_high_nibble_out, port_a_low_byte_out},
          {core_suspend_out, core_high_out, core_low_out} & pmask(em, base));
      chk(channel_b_blocked, em == 7);
      apb(1'b0, `CHAMPM_OFS_STATUS, 0);
      chk(rd & 32'h0000_060f, {21'h0, bad, em != 6 && em != 7, 5'h00, 4'(em)});
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, config_valid, config_base_mode} = '0;
      {channel_b_mode, channel_b_bitmode_engine_req, config_present, config_blank} = 5'h03;
      void'($urandom(32'h8fc8));
      {core_low_out, core_high_out, core_suspend_out, core_low_oe} = 21'($urandom);
      {core_high_oe, core_suspend_oe, ext_drive} = {5'h1f, 13'($urandom)};
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      #1;
      chk(active_mode, 0);
      apb(1'b1, `CHAMPM_OFS_BASE, 1);
      apb(1'b0, `CHAMPM_OFS_BASE, 0);
      chk(rd, `CHAMPM_RST_BASE);
      apb(1'b1, 12'h01c, 2);
      chk({err, active_mode}, 5'h10);
      repeat (6) @(posedge pclk);
      #1;
      chk(core_low_in, (core_low_out & core_low_oe) | (ext_drive[7:0] & ~core_low_oe));
      chk({core_suspend_in, core_high_in}, {core_suspend_out, core_high_out});
      $display("test reset and serial done");
      @(posedge pclk);
      channel_b_bitmode_engine_req <= 1'b1;
      config_blank <= 1'b0;
      apb(1'b0, `CHAMPM_OFS_CHB, 0);
      chk(rd[3], 1'b1);
      for (b = 0; b < 4; b++) begin
         @(posedge pclk);
         config_base_mode <= 3'(b);
         config_valid <= 1'b1;
         @(posedge pclk);
         config_valid <= 1'b0;
         foreach (bms[k]) go(b, bms[k]);
         $display("test base %0d done", b);
      end
      go(3, 16);
      chk(opto_held_reset, 1'b1);
      go(3, 0);
      chk(opto_held_reset, 1'b0);
      channel_b_mode <= 2'h1;
      go(3, 0);
      go(3, 1);
      $display("test opto done");
      conclude();
   end
endmodule // tb_champm_mux
`default_nettype wire
